//--- verilog/ccs_node.sv
// Command decoder and response sequencer for one node of the monitor chain.
`include "ccs_defs.svh"
`default_nettype none
module ccs_node #(
    parameter int FIFO_DEPTH = 4,
    parameter int LVL_W = $clog2(FIFO_DEPTH + 1)
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Command stream from the host side and forwarded copy.
    input wire ccs_pkg::ccs_byte_type cmd_in,
    output var ccs_pkg::ccs_byte_type cmd_out,
    // Response stream from the node above.
    input wire ccs_pkg::ccs_byte_type rsp_up_in,
    output var logic rsp_up_ready,
    // Response stream toward the host.
    output var ccs_pkg::ccs_byte_type rsp_out,
    input wire logic rsp_out_ready,
    // Node configuration.
    input wire logic [7:0] node_addr,
    input wire logic stack_member_flag,
    input wire logic top_of_stack_flag,
    // Register file access.
    output var logic reg_wr_en,
    output var logic [15:0] reg_wr_addr,
    output var logic [7:0] reg_wr_data,
    output var logic [15:0] reg_rd_addr,
    input wire logic [7:0] reg_rd_data,
    // Status.
    output var logic crc_err,
    output var logic rsp_crc_fault,
    output var logic busy
);
    // --------
    // Declarations
    // --------
    ccs_pkg::ccs_state_type st;
    ccs_pkg::ccs_state_type next_st;
    logic [15:0] cmd_crc_in;
    logic [15:0] cmd_crc;
    logic [15:0] up_crc_in;
    logic [15:0] up_crc;
    logic [15:0] tx_crc;
    logic up_take;
    logic tx_emit;
    logic tx_push;
    logic [7:0] tx_byte;
    logic fifo_in_valid;
    logic [7:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_out_ready;
    logic [LVL_W-1:0] fifo_level;
    logic addr_match;

    // --------
    // Outputs
    // --------
    assign cmd_out = st.cmd_out;
    assign rsp_up_ready = st.up_ready;
    assign rsp_out = st.rsp_out;
    assign reg_wr_en = st.reg_wr_en;
    assign reg_wr_addr = st.reg_wr_addr;
    assign reg_wr_data = st.reg_wr_data;
    assign reg_rd_addr = st.reg_rd_addr;
    assign crc_err = st.crc_err;
    assign rsp_crc_fault = st.rsp_crc_fault;
    assign busy = st.busy;

    // --------
    // Kind decode of an initialization byte
    // --------
    function automatic ccs_pkg::ccs_kind_type decode_kind(input logic [7:0] b);
        ccs_pkg::ccs_kind_type k;
        k = ccs_pkg::K_OTHER;
        // R6: single read code
        if (b == `CCS_INIT_SINGLE_RD) begin
            k = ccs_pkg::K_SINGLE_RD;
        end
        // R7: stack read code
        if (b == `CCS_INIT_STACK_RD) begin
            k = ccs_pkg::K_STACK_RD;
        end
        // R5: single write codes
        if ((b & `CCS_INIT_KIND_MASK) == `CCS_INIT_SINGLE_WR) begin
            k = ccs_pkg::K_SINGLE_WR;
        end
        // R8: stack write codes
        if ((b & `CCS_INIT_KIND_MASK) == `CCS_INIT_STACK_WR) begin
            k = ccs_pkg::K_STACK_WR;
        end
        return k;
    endfunction : decode_kind

    // --------
    // CRC steppers
    // --------
    // R21: preset all ones
    assign cmd_crc_in = (st.cp == ccs_pkg::P_INIT) ? `CCS_CRC_PRESET : st.ccrc;
    assign up_crc_in = (st.up == ccs_pkg::P_INIT) ? `CCS_CRC_PRESET : st.ucrc;

    ccs_crc_step u_cmd_crc (
        .crc_in(cmd_crc_in),
        .data(cmd_in.data),
        .crc_out(cmd_crc)
    );

    ccs_crc_step u_up_crc (
        .crc_in(up_crc_in),
        .data(rsp_up_in.data),
        .crc_out(up_crc)
    );

    ccs_crc_step u_tx_crc (
        .crc_in(st.tcrc),
        .data(tx_byte),
        .crc_out(tx_crc)
    );

    // --------
    // Response byte source and FIFO feed
    // --------
    assign addr_match = (st.cdev == node_addr);
    assign up_take = rsp_up_in.valid & st.up_ready;

    always_comb begin
        tx_emit = 1'b1;
        tx_byte = 8'h00;
        case (st.tx)
            // R17: six protocol bytes around data
            ccs_pkg::T_INIT: tx_byte = {1'b0, st.tlen};
            // R18: own address in response
            ccs_pkg::T_DEV: tx_byte = node_addr;
            ccs_pkg::T_REG_HI: tx_byte = st.taddr[15:8];
            ccs_pkg::T_REG_LO: tx_byte = st.taddr[7:0];
            ccs_pkg::T_DATA: tx_byte = reg_rd_data;
            ccs_pkg::T_CRC_LO: tx_byte = st.tcrc[7:0];
            ccs_pkg::T_CRC_HI: tx_byte = st.tcrc[15:8];
            default: tx_emit = 1'b0;
        endcase
    end

    // Upstream bytes pass first so the chain above is never dropped.
    assign tx_push = tx_emit & ~up_take & fifo_in_ready;
    assign fifo_in_valid = up_take | tx_push;
    assign fifo_in_data = up_take ? rsp_up_in.data : tx_byte;
    assign fifo_out_ready = ~st.rsp_out.valid | rsp_out_ready;

    ccs_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .LVL_W(LVL_W)
    ) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in_data),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_out_ready),
        .level(fifo_level)
    );

    // --------
    // Next state
    // --------
    always_comb begin
        next_st = st;
        // R25: forward every command byte
        next_st.cmd_out = cmd_in;
        next_st.reg_wr_en = 1'b0;
        next_st.crc_err = 1'b0;
        next_st.rsp_crc_fault = 1'b0;
        next_st.up_ready = (int'(fifo_level) <= FIFO_DEPTH - 2);
        if (fifo_out_ready) begin
            next_st.rsp_out.valid = fifo_out_valid;
            next_st.rsp_out.data = fifo_out_data;
        end

        // Register writes, one per cycle.
        if (st.wbusy) begin
            // R20: consecutive register addresses
            next_st.reg_wr_en = 1'b1;
            next_st.reg_wr_addr = st.waddr;
            next_st.reg_wr_data = st.wdata[0];
            next_st.waddr = st.waddr + 16'h0001;
            next_st.wdata = {8'h00, st.wdata[7:1]};
            next_st.wleft = st.wleft - 3'h1;
            if (st.wleft == 3'h0) begin
                next_st.wbusy = 1'b0;
            end
        end

        // Response transmission.
        if (st.tx == ccs_pkg::T_FETCH) begin
            next_st.reg_rd_addr = st.taddr;
            next_st.tx = ccs_pkg::T_DATA;
        end
        if (tx_push) begin
            // R21: CRC over own response
            if (st.tx != ccs_pkg::T_CRC_LO && st.tx != ccs_pkg::T_CRC_HI) begin
                next_st.tcrc = tx_crc;
            end
            case (st.tx)
                ccs_pkg::T_INIT: next_st.tx = ccs_pkg::T_DEV;
                ccs_pkg::T_DEV: next_st.tx = ccs_pkg::T_REG_HI;
                ccs_pkg::T_REG_HI: next_st.tx = ccs_pkg::T_REG_LO;
                ccs_pkg::T_REG_LO: next_st.tx = ccs_pkg::T_FETCH;
                ccs_pkg::T_DATA: begin
                    // R16: count plus one bytes
                    next_st.taddr = st.taddr + 16'h0001;
                    next_st.tcnt = st.tcnt + 7'h01;
                    next_st.tx = (st.tcnt == st.tlen) ? ccs_pkg::T_CRC_LO : ccs_pkg::T_FETCH;
                end
                ccs_pkg::T_CRC_LO: next_st.tx = ccs_pkg::T_CRC_HI;
                default: next_st.tx = ccs_pkg::T_IDLE;
            endcase
        end

        // Command frame parser.
        if (cmd_in.valid) begin
            next_st.ccrc = cmd_crc;
            case (st.cp)
                ccs_pkg::P_INIT: begin
                    if (cmd_in.data[`CCS_FRAME_CMD_BIT]) begin
                        next_st.ck = decode_kind(cmd_in.data);
                        // R3: length code is data byte count minus one
                        next_st.csize = cmd_in.data[2:0];
                        next_st.cidx = 3'h0;
                        // R10: stack frames skip the address
                        if (cmd_in.data[`CCS_REQ_MSB:`CCS_REQ_LSB] <= `CCS_REQ_ADDRESSED_MAX) begin
                            next_st.cp = ccs_pkg::P_DEV;
                        end else begin
                            next_st.cp = ccs_pkg::P_REG_HI;
                        end
                    end
                end
                ccs_pkg::P_DEV: begin
                    next_st.cdev = cmd_in.data;
                    next_st.cp = ccs_pkg::P_REG_HI;
                end
                ccs_pkg::P_REG_HI: begin
                    next_st.creg[15:8] = cmd_in.data;
                    next_st.cp = ccs_pkg::P_REG_LO;
                end
                ccs_pkg::P_REG_LO: begin
                    next_st.creg[7:0] = cmd_in.data;
                    next_st.cp = ccs_pkg::P_DATA;
                end
                ccs_pkg::P_DATA: begin
                    // R2: at most eight data bytes
                    next_st.cdata[st.cidx] = cmd_in.data;
                    next_st.cidx = st.cidx + 3'h1;
                    if (st.cidx == st.csize) begin
                        next_st.cp = ccs_pkg::P_CRC_LO;
                    end
                end
                ccs_pkg::P_CRC_LO: next_st.cp = ccs_pkg::P_CRC_HI;
                ccs_pkg::P_CRC_HI: begin
                    next_st.cp = ccs_pkg::P_INIT;
                    if (cmd_crc != 16'h0000) begin
                        // R22: drop frame on bad CRC
                        next_st.crc_err = 1'b1;
                    end else begin
                        // R4: single write on match
                        if ((st.ck == ccs_pkg::K_SINGLE_WR && addr_match) ||
                            // R19: stack write on members
                            (st.ck == ccs_pkg::K_STACK_WR && stack_member_flag)) begin
                            if (!next_st.wbusy) begin
                                next_st.wbusy = 1'b1;
                                next_st.wleft = st.csize;
                                next_st.waddr = st.creg;
                                next_st.wdata = st.cdata;
                            end
                        end
                        if (st.tx == ccs_pkg::T_IDLE && !st.pend) begin
                            // R15: byte count from data byte
                            next_st.taddr = st.creg;
                            next_st.tlen = st.cdata[0][6:0];
                            next_st.tcnt = 7'h00;
                            next_st.tcrc = `CCS_CRC_PRESET;
                            // R24: single read on match
                            if (st.ck == ccs_pkg::K_SINGLE_RD && addr_match) begin
                                next_st.tx = ccs_pkg::T_INIT;
                            end
                            // R11: members answer stack reads
                            if (st.ck == ccs_pkg::K_STACK_RD && stack_member_flag) begin
                                // R12: top node sends first
                                if (top_of_stack_flag) begin
                                    next_st.tx = ccs_pkg::T_INIT;
                                end else begin
                                    next_st.pend = 1'b1;
                                end
                            end
                        end
                    end
                end
                default: next_st.cp = ccs_pkg::P_INIT;
            endcase
        end

        // Response parser for frames from the node above.
        if (up_take) begin
            next_st.ucrc = up_crc;
            case (st.up)
                ccs_pkg::P_INIT: begin
                    if (!rsp_up_in.data[`CCS_FRAME_CMD_BIT]) begin
                        next_st.ulen = rsp_up_in.data[6:0];
                        next_st.ucnt = 7'h00;
                        next_st.up = ccs_pkg::P_DEV;
                    end
                end
                ccs_pkg::P_DEV: next_st.up = ccs_pkg::P_REG_HI;
                ccs_pkg::P_REG_HI: next_st.up = ccs_pkg::P_REG_LO;
                ccs_pkg::P_REG_LO: next_st.up = ccs_pkg::P_DATA;
                ccs_pkg::P_DATA: begin
                    next_st.ucnt = st.ucnt + 7'h01;
                    if (st.ucnt == st.ulen) begin
                        next_st.up = ccs_pkg::P_CRC_LO;
                    end
                end
                ccs_pkg::P_CRC_LO: next_st.up = ccs_pkg::P_CRC_HI;
                ccs_pkg::P_CRC_HI: begin
                    next_st.up = ccs_pkg::P_INIT;
                    if (up_crc != 16'h0000) begin
                        // R14: withhold and flag fault
                        next_st.rsp_crc_fault = 1'b1;
                        next_st.pend = 1'b0;
                    end else if (st.pend) begin
                        // R13: append after node above
                        next_st.pend = 1'b0;
                        next_st.tx = ccs_pkg::T_INIT;
                    end
                end
                default: next_st.up = ccs_pkg::P_INIT;
            endcase
        end

        next_st.busy = next_st.wbusy | next_st.pend | (next_st.tx != ccs_pkg::T_IDLE);
    end

    // --------
    // State register
    // --------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ccs_node
`default_nettype wire

//--- verilog/ccs_defs.svh
// Frame codes, field positions and CRC constants of the chain command interpreter.
// Operation
// R1: Host addresses all nodes before single writes.
// R2: Single write updates up to eight registers.
// R3: Length code gives count of registers written; the code writes length code plus one registers.
// R4: Single write executes only on address match.
// R5: Single write codes 0x90 to 0x97.
// R6: Single read uses initialization byte 0x80.
// R7: Stack read uses initialization byte 0xA0.
// R8: Stack write codes 0xB0 to 0xB7.
// R9: Host configures address and stack flags first.
// R10: Stack frames carry no device address byte.
// R11: Only stack members answer stack reads.
// R12: Top node answers first without waiting.
// R13: Node N waits for node N+1 response.
// R14: Bad upstream CRC withholds response, raises fault.
// R15: Read length code is always zero.
// R16: Read returns data byte plus one bytes.
// R17: Response adds six protocol bytes to data.
// R18: Response carries responding node's own address.
// R19: Stack write executes only on stack members.
// R20: Accesses run from start register upward.
// R21: CRC-16 x16+x15+x2+1, preset all ones.
// R22: Bad command CRC drops frame, flags error.
// R23: Bytes least significant bit first in CRC.
// R24: Single read answered only on address match.
// R25: Every command byte is forwarded unchanged.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
`define CCS_FRAME_CMD_BIT 7
`define CCS_REQ_MSB 6
`define CCS_REQ_LSB 4
`define CCS_REQ_ADDRESSED_MAX 3'h1
`define CCS_INIT_KIND_MASK 8'hf8
`define CCS_INIT_SINGLE_RD 8'h80
`define CCS_INIT_SINGLE_WR 8'h90
`define CCS_INIT_STACK_RD 8'ha0
`define CCS_INIT_STACK_WR 8'hb0
`define CCS_CRC_PRESET 16'hffff
`define CCS_CRC_POLY_REFL 16'ha001
`define CCS_RSP_PROTO_BYTES 6
`endif

//--- verilog/ccs_pkg.sv
// Types shared by the chain command interpreter.
`default_nettype none
package ccs_pkg;
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ccs_byte_type;
    typedef enum logic [2:0] {P_INIT, P_DEV, P_REG_HI, P_REG_LO, P_DATA, P_CRC_LO, P_CRC_HI} ccs_parse_type;
    typedef enum logic [3:0] {T_IDLE, T_INIT, T_DEV, T_REG_HI, T_REG_LO, T_FETCH, T_DATA, T_CRC_LO,
                              T_CRC_HI} ccs_tx_type;
    typedef enum logic [2:0] {K_NONE, K_SINGLE_RD, K_SINGLE_WR, K_STACK_RD, K_STACK_WR, K_OTHER} ccs_kind_type;
    typedef struct packed {
        ccs_parse_type cp;
        ccs_kind_type ck;
        logic [2:0] csize;
        logic [2:0] cidx;
        logic [7:0] cdev;
        logic [15:0] creg;
        logic [7:0][7:0] cdata;
        logic [15:0] ccrc;
        ccs_parse_type up;
        logic [6:0] ulen;
        logic [6:0] ucnt;
        logic [15:0] ucrc;
        ccs_tx_type tx;
        logic [6:0] tlen;
        logic [6:0] tcnt;
        logic [15:0] taddr;
        logic [15:0] tcrc;
        logic pend;
        logic wbusy;
        logic [2:0] wleft;
        logic [15:0] waddr;
        logic [7:0][7:0] wdata;
        ccs_byte_type cmd_out;
        ccs_byte_type rsp_out;
        logic up_ready;
        logic reg_wr_en;
        logic [15:0] reg_wr_addr;
        logic [7:0] reg_wr_data;
        logic [15:0] reg_rd_addr;
        logic crc_err;
        logic rsp_crc_fault;
        logic busy;
    } ccs_state_type;
endpackage : ccs_pkg
`default_nettype wire

//--- verilog/ccs_crc_step.sv
// One byte step of the frame CRC, least significant bit first.
`include "ccs_defs.svh"
`default_nettype none
module ccs_crc_step #(
    parameter logic [15:0] POLY = `CCS_CRC_POLY_REFL
) (
    // Running value and byte.
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data,
    // Updated value.
    output logic [15:0] crc_out
);
    // R23: LSB first order
    always_comb begin
        crc_out = crc_in ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            crc_out = crc_out[0] ? ((crc_out >> 1) ^ POLY) : (crc_out >> 1);
        end
    end
endmodule : ccs_crc_step
`default_nettype wire

//--- verilog/ccs_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none
module ccs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Filling side.
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side.
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // Fill level.
    output logic [LVL_W-1:0] level
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PTR_W-1:0] rd;
        logic [PTR_W-1:0] wr;
        logic [LVL_W-1:0] count;
    } ccs_fifo_state_type;
    ccs_fifo_state_type st;
    ccs_fifo_state_type next_st;
    logic push;
    logic pop;

    assign in_ready = (st.count != LVL_W'(DEPTH));
    assign out_valid = (st.count != '0);
    assign out_data = st.mem[st.rd];
    assign level = st.count;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = (st.wr == PTR_W'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = (st.rd == PTR_W'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
        end
        next_st.count = st.count + LVL_W'(push) - LVL_W'(pop);
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : ccs_fifo
`default_nettype wire

//--- testbench/ccs_node_sva.sv
// Concurrent checks on the ports of the chain node.
`default_nettype none
module ccs_node_sva (
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Observed ports.
    input wire ccs_pkg::ccs_byte_type cmd_in,
    input wire ccs_pkg::ccs_byte_type cmd_out,
    input wire ccs_pkg::ccs_byte_type rsp_out,
    input wire logic rsp_out_ready,
    input wire logic reg_wr_en,
    input wire logic [15:0] reg_wr_addr,
    input wire logic crc_err,
    input wire logic rsp_crc_fault,
    input wire logic busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic [3:0] run;
    // Counts back-to-back register writes of one burst.
    always_ff @(posedge clock) begin
        if (!nrst || !reg_wr_en) begin
            run <= 4'h0;
        end else if (run != 4'hf) begin
            run <= run + 4'h1;
        end
    end
    a_cmd_fwd_copy: assert property (cmd_out == $past(cmd_in))
        else $error("fwd differs");
    a_wr_addr_step: assert property (reg_wr_en && $past(reg_wr_en) |-> reg_wr_addr == $past(reg_wr_addr) + 16'h1)
        else $error("wr addr gap");
    a_wr_burst_len: assert property (run <= 4'h8)
        else $error("burst too long");
    a_wr_while_busy: assert property (reg_wr_en |-> $past(busy))
        else $error("wr not busy");
    a_crc_no_write: assert property (crc_err |-> !reg_wr_en ##1 !reg_wr_en)
        else $error("wr after bad crc");
    a_crc_err_pulse: assert property (crc_err |=> !crc_err)
        else $error("crc_err not a pulse");
    a_fault_pulse: assert property (rsp_crc_fault |=> !rsp_crc_fault)
        else $error("fault not a pulse");
    a_rsp_hold_stall: assert property (rsp_out.valid && !rsp_out_ready |=> rsp_out.valid && $stable(rsp_out.data))
        else $error("stalled byte lost");
endmodule : ccs_node_sva
`default_nettype wire

//--- testbench/ccs_up_model.sv
// Model of the node above and of the register file behind this node.
`default_nettype none
module ccs_up_model (
    // Clock.
    input wire logic clock,
    // Response stream into the node.
    output var ccs_pkg::ccs_byte_type rsp_up_in,
    input wire logic rsp_up_ready,
    // Register file.
    input wire logic [15:0] reg_rd_addr,
    output var logic [7:0] reg_rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rsp_up_in = '0;
    assign reg_rd_data = reg_rd_addr[7:0] ^ reg_rd_addr[15:8] ^ 8'h5a;
    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
        return r;
    endfunction : crc_byte
    // one frame of the node above.
    task automatic send(input logic [7:0] addr, input int n, input logic bad);
        logic [7:0] q[$];
        logic [15:0] c;
        q = '{8'(n - 1), addr, 8'h05, 8'h68};
        for (int i = 0; i < n; i++) q.push_back(8'h40 + 8'(i));
        c = 16'hffff;
        foreach (q[i]) c = crc_byte(c, q[i]);
        q.push_back(c[7:0] ^ {7'h00, bad});
        q.push_back(c[15:8]);
        foreach (q[i]) begin
            @(negedge clock);
            rsp_up_in <= '{valid: 1'b1, data: q[i]};
            while (!rsp_up_ready) @(negedge clock);
            @(posedge clock);
        end
        @(negedge clock);
        rsp_up_in <= '{valid: 1'b0, data: ~rsp_up_in.data};
    endtask : send
endmodule : ccs_up_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the chain node.
`default_nettype none
`define CHK(a, b, m) begin total_checks++; if ((a) !== (b)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    ccs_pkg::ccs_byte_type cmd_in = '0;
    ccs_pkg::ccs_byte_type cmd_out, rsp_up_in, rsp_out;
    logic rsp_up_ready, reg_wr_en, crc_err, rsp_crc_fault, busy;
    logic rsp_out_ready = 1'b1;
    logic member = 1'b0;
    logic top = 1'b0;
    logic [15:0] reg_wr_addr, reg_rd_addr;
    logic [7:0] reg_wr_data, reg_rd_data;
    logic [7:0] rq[$];
    logic [23:0] wq[$];
    int errs_seen = 0, faults_seen = 0, fails = 0, total_checks = 0;
    always #5 clock = ~clock;
    // address and flags set before commands
    ccs_node dut_u (.clock(clock), .nrst(nrst), .cmd_in(cmd_in), .cmd_out(cmd_out), .rsp_up_in(rsp_up_in),
        .rsp_up_ready(rsp_up_ready), .rsp_out(rsp_out), .rsp_out_ready(rsp_out_ready), .node_addr(8'h05),
        .stack_member_flag(member), .top_of_stack_flag(top), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .crc_err(crc_err),
        .rsp_crc_fault(rsp_crc_fault), .busy(busy));
    ccs_up_model up_u (.clock(clock), .rsp_up_in(rsp_up_in), .rsp_up_ready(rsp_up_ready),
        .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data));
    always @(posedge clock) begin
        if (rsp_out.valid && rsp_out_ready) rq.push_back(rsp_out.data);
        if (reg_wr_en) wq.push_back({reg_wr_addr, reg_wr_data});
        if (crc_err) errs_seen++;
        if (rsp_crc_fault) faults_seen++;
    end
    task automatic end_sim();
        $display("TB: %0d checks, %0d mismatches", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic tend(input string name);
        $display("TB: test %s done", name);
        rq.delete();
        wq.delete();
    endtask : tend
    task automatic send_cmd(input logic [7:0] b[$], input logic bad);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) c = up_u.crc_byte(c, b[i]);
        b.push_back(c[7:0]);
        b.push_back(c[15:8] ^ {7'h00, bad});
        foreach (b[i]) begin
            @(negedge clock);
            cmd_in <= '{valid: 1'b1, data: b[i]};
        end
        @(negedge clock);
        cmd_in <= '{valid: 1'b0, data: 8'h00};
        repeat (40) @(negedge clock);
    endtask : send_cmd
    task automatic chk_wr(input int n, input logic [23:0] first);
        `CHK(wq.size(), n, "write count")
        if (n > 0) `CHK(wq[0], first, "first write")
        if (n > 0) `CHK(wq[n - 1][23:8], first[23:8] + 16'(n - 1), "last write address")
        wq.delete();
    endtask : chk_wr
    task automatic wait_rq(input int need);
        for (int i = 0; i < 300 && rq.size() < need; i++) @(negedge clock);
        `CHK(rq.size(), need, "response byte count")
    endtask : wait_rq
    task automatic chk_frame(input int b, input int n, input logic [7:0] addr, input logic own);
        logic [15:0] c;
        c = 16'hffff;
        `CHK(rq[b], 8'(n - 1), "response length code")
        `CHK(rq[b + 1], addr, "response address")
        `CHK({rq[b + 2], rq[b + 3]}, 16'h0568, "response register")
        for (int i = 0; i < n; i++) `CHK(rq[b + 4 + i], own ? ((8'h68 + 8'(i)) ^ 8'h5f) : 8'h40 + 8'(i), "data")
        for (int i = 0; i < n + 6; i++) c = up_u.crc_byte(c, rq[b + i]);
        `CHK(c, 16'h0000, "response crc")
    endtask : chk_frame
    initial begin
        repeat (12) @(negedge clock);
        nrst <= 1'b1;
        send_cmd('{8'h93, 8'h05, 8'h03, 8'h00, 8'h02, 8'hb7, 8'h78, 8'hbc}, 1'b0);
        chk_wr(4, 24'h030002);
        tend("single write");
        send_cmd('{8'h93, 8'h06, 8'h03, 8'h00, 8'h02, 8'hb7, 8'h78, 8'hbc}, 1'b0);
        chk_wr(0, 24'h0);
        send_cmd('{8'h97, 8'h05, 8'h00, 8'h10, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h88}, 1'b0);
        chk_wr(8, 24'h001011);
        send_cmd('{8'h90, 8'h05, 8'h00, 8'h10, 8'h11}, 1'b1);
        chk_wr(0, 24'h0);
        `CHK(errs_seen, 1, "command crc error count")
        tend("write limits");
        for (int m = 0; m < 2; m++) begin
            member <= m[0];
            send_cmd('{8'hb1, 8'h00, 8'h20, 8'haa, 8'hbb}, 1'b0);
            chk_wr(2 * m, 24'h0020aa);
        end
        tend("stack write");
        rsp_out_ready <= 1'b0;
        send_cmd('{8'h80, 8'h05, 8'h05, 8'h68, 8'h01}, 1'b0);
        rsp_out_ready <= 1'b1;
        wait_rq(8);
        chk_frame(0, 2, 8'h05, 1'b1);
        tend("single read");
        send_cmd('{8'h80, 8'h06, 8'h05, 8'h68, 8'h01}, 1'b0);
        `CHK(rq.size(), 0, "foreign read answered")
        top <= 1'b1;
        send_cmd('{8'ha0, 8'h05, 8'h68, 8'h00}, 1'b0);
        wait_rq(7);
        chk_frame(0, 1, 8'h05, 1'b1);
        tend("top stack read");
        top <= 1'b0;
        send_cmd('{8'ha0, 8'h05, 8'h68, 8'h00}, 1'b0);
        up_u.send(8'h06, 1, 1'b0);
        wait_rq(14);
        chk_frame(0, 1, 8'h06, 1'b0);
        chk_frame(7, 1, 8'h05, 1'b1);
        tend("chained stack read");
        send_cmd('{8'ha0, 8'h05, 8'h68, 8'h00}, 1'b0);
        up_u.send(8'h06, 1, 1'b1);
        repeat (40) @(negedge clock);
        `CHK(faults_seen, 1, "upstream fault count")
        `CHK(rq.size(), 7, "own frame withheld")
        tend("bad upstream");
        member <= 1'b0;
        top <= 1'b1;
        send_cmd('{8'ha0, 8'h05, 8'h68, 8'h00}, 1'b0);
        `CHK(rq.size(), 0, "non-member answered")
        tend("non-member read");
        end_sim();
    end
    initial begin
        #100us;
        fails++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_sim();
    end
endmodule : tb
bind ccs_node ccs_node_sva chk_u (.clock(clock), .nrst(nrst), .cmd_in(cmd_in), .cmd_out(cmd_out),
    .rsp_out(rsp_out), .rsp_out_ready(rsp_out_ready), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .crc_err(crc_err), .rsp_crc_fault(rsp_crc_fault), .busy(busy));
`default_nettype wire
